// ==== hw/mpa_motor_pwm.sv ====
/*
  Three-pair complementary PWM with dead time and fault shutdown, delay
  unit for ADC pre-triggers, comparator filter, slow tick, SPI port.
  Assumes an APB master, ADCs that pulse adc_done_i with valid results.
*/
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "mpa_cfg.svh"
module mpa_motor_pwm #(
  parameter int ADC_W  = `MPA_ADC_W,
  parameter int FILT_N = `MPA_FILT_N
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  output logic [7:0]            pwm_o,
  input  wire logic             fault_pin_i,
  input  wire logic             cmp_raw_i,
  output logic [5:0]            cmp_ref_o,
  output logic                  reload_trig_o,
  output logic [1:0]            adc_pretrig_o,
  output logic [1:0]            adc_slot_o,
  input  wire logic [1:0]       adc_done_i,
  input  wire logic [ADC_W-1:0] adc0_result_i,
  input  wire logic [ADC_W-1:0] adc1_result_i,
  output logic                  fast_loop_irq_o,
  output logic                  delay_irq_o,
  output logic                  slow_irq_o,
  output logic                  spi_sclk_o,
  output logic                  spi_mosi_o,
  input  wire logic             spi_miso_i,
  output logic                  spi_cs_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [5:0]       ctrl, next_ctrl, next_cmpref;
  logic [15:0]      counter_initial_value, modv, idly, speed;
  logic [15:0]      next_counter_initial_value, next_modv, next_idly, next_speed;
  logic [15:0]      duty [3];
  logic [15:0]      next_duty [3];
  logic [7:0]       dead, pretrig, omask;
  logic [7:0]       next_dead, next_pretrig, next_omask;
  logic             dflag, seq_flag, flt, next_dflag, next_seq, next_flt;
  logic [31:0]      rd_val, next_prdata;
  logic             hit, next_slverr, wr, wr_stat, rd_acc, man_clr;
  logic [3:0]       rd_clr, unread_all;
  logic [ADC_W-1:0] res_all [4];
  logic [ADC_W-1:0] adc_data [2];
  logic [1:0]       seq_ev, first_done;
  logic             spi_busy;
  logic [7:0]       spi_rx;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pwrite_i;
  assign wr_stat = wr && (paddr_i == `MPA_A_STATUS);
  assign man_clr = wr_stat & pwdata_i[`MPA_S_FLT] & ~ctrl[`MPA_C_ACLR];
  assign pready_o = psel_i & penable_i;
  assign adc_data[0] = adc0_result_i;
  assign adc_data[1] = adc1_result_i;

  // Timer tick, main counter, reload trigger and delay counter.
  logic [3:0]  acc, next_acc, sum;
  logic        tick, reload, next_trig, dly_run, next_dly_run;
  logic [15:0] cnt, next_cnt, dly_cnt, next_dly_cnt;
  logic        pre0_hit, idly_hit, fault_in, cmp_filt;
  logic [5:0]  cmpref_q;
  assign cmp_ref_o = cmpref_q;

  always_comb begin
    sum = acc + `MPA_TICK_STEP;
    tick = (sum >= `MPA_TICK_WRAP);
    next_acc = tick ? sum - `MPA_TICK_WRAP : sum;
    reload = tick && ($signed(cnt) >= $signed(modv));
    next_cnt = cnt;
    if (tick) begin
      next_cnt = reload ? counter_initial_value : cnt + 16'h0001;
    end
    next_trig = reload & ctrl[`MPA_C_GATE];
    next_dly_cnt = dly_cnt;
    next_dly_run = dly_run;
    if (reload_trig_o) begin
      next_dly_cnt = 16'h0000;
      next_dly_run = 1'b1;
    end else if (tick && dly_run) begin
      if (dly_cnt == 16'hffff) begin
        next_dly_run = 1'b0;
      end else begin
        next_dly_cnt = dly_cnt + 16'h0001;
      end
    end
    pre0_hit = tick && dly_run && (dly_cnt == {8'h00, pretrig});
    idly_hit = tick && dly_run && (dly_cnt == idly);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc <= 4'h0;
      cnt <= `MPA_R_COUNTER_INITIAL_VALUE;
      reload_trig_o <= 1'b0;
      dly_cnt <= 16'h0000;
      dly_run <= 1'b0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      reload_trig_o <= next_trig;
      dly_cnt <= next_dly_cnt;
      dly_run <= next_dly_run;
    end
  end

  // Register writes, status flags and the fault latch.
  always_comb begin
    next_ctrl = ctrl;
    next_counter_initial_value = counter_initial_value;
    next_modv = modv;
    next_idly = idly;
    next_speed = speed;
    next_duty = duty;
    next_dead = dead;
    next_pretrig = pretrig;
    next_omask = omask;
    next_cmpref = cmpref_q;
    if (wr) begin
      case (paddr_i)
        `MPA_A_CTRL:    next_ctrl = pwdata_i[5:0];
        `MPA_A_COUNTER_INITIAL_VALUE:   next_counter_initial_value = pwdata_i[15:0];
        `MPA_A_MOD:     next_modv = pwdata_i[15:0];
        `MPA_A_DUTY0:   next_duty[0] = pwdata_i[15:0];
        `MPA_A_DUTY1:   next_duty[1] = pwdata_i[15:0];
        `MPA_A_DUTY2:   next_duty[2] = pwdata_i[15:0];
        `MPA_A_DEAD:    next_dead = pwdata_i[7:0];
        `MPA_A_PRETRIG: next_pretrig = pwdata_i[7:0];
        `MPA_A_IDLY:    next_idly = pwdata_i[15:0];
        `MPA_A_MASK:    next_omask = pwdata_i[7:0];
        `MPA_A_SPEED:   next_speed = pwdata_i[15:0];
        `MPA_A_CMPREF:  next_cmpref = pwdata_i[5:0];
        default:        next_ctrl = ctrl;
      endcase
    end
    next_dflag = (dflag & ~(wr_stat & pwdata_i[`MPA_S_DLY])) | idly_hit;
    next_seq = (seq_flag & ~(wr_stat & pwdata_i[`MPA_S_ERR])) | (|seq_ev);
    fault_in = (fault_pin_i ^ ctrl[`MPA_C_FPOL]) | cmp_filt;
    next_flt = fault_in |
      (flt & ~((reload & ctrl[`MPA_C_ACLR]) | man_clr));
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl <= `MPA_R_CTRL;
      counter_initial_value <= `MPA_R_COUNTER_INITIAL_VALUE;
      modv <= `MPA_R_MOD;
      idly <= `MPA_R_IDLY;
      speed <= `MPA_R_SPEED;
      duty <= '{16'h0000, 16'h0000, 16'h0000};
      dead <= 8'(`MPA_DEAD_CNT);
      pretrig <= 8'(`MPA_DEAD_CNT / 2);
      omask <= `MPA_R_MASK;
      cmpref_q <= `MPA_R_CMPREF;
      dflag <= 1'b0;
      seq_flag <= 1'b0;
      flt <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      counter_initial_value <= next_counter_initial_value;
      modv <= next_modv;
      idly <= next_idly;
      speed <= next_speed;
      duty <= next_duty;
      dead <= next_dead;
      pretrig <= next_pretrig;
      omask <= next_omask;
      cmpref_q <= next_cmpref;
      dflag <= next_dflag;
      seq_flag <= next_seq;
      flt <= next_flt;
    end
  end

  assign delay_irq_o = dflag | seq_flag;

  // Read data and error are set up in the setup phase.
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    case (paddr_i)
      `MPA_A_CTRL:    rd_val = {26'h0, ctrl};
      `MPA_A_STATUS:  rd_val = {25'h0, spi_busy, fault_pin_i, cmp_filt,
                                1'b0, flt, seq_flag, dflag};
      `MPA_A_COUNTER_INITIAL_VALUE:   rd_val = {16'h0, counter_initial_value};
      `MPA_A_MOD:     rd_val = {16'h0, modv};
      `MPA_A_DUTY0:   rd_val = {16'h0, duty[0]};
      `MPA_A_DUTY1:   rd_val = {16'h0, duty[1]};
      `MPA_A_DUTY2:   rd_val = {16'h0, duty[2]};
      `MPA_A_DEAD:    rd_val = {24'h0, dead};
      `MPA_A_PRETRIG: rd_val = {24'h0, pretrig};
      `MPA_A_IDLY:    rd_val = {16'h0, idly};
      `MPA_A_MASK:    rd_val = {24'h0, omask};
      `MPA_A_SPEED:   rd_val = {16'h0, speed};
      `MPA_A_CMPREF:  rd_val = {26'h0, cmpref_q};
      `MPA_A_SPI:     rd_val = {23'h0, spi_busy, spi_rx};
      `MPA_A_RES0A:   rd_val = 32'(res_all[0]);
      `MPA_A_RES0B:   rd_val = 32'(res_all[1]);
      `MPA_A_RES1A:   rd_val = 32'(res_all[2]);
      `MPA_A_RES1B:   rd_val = 32'(res_all[3]);
      default:        hit = 1'b0;
    endcase
    next_prdata = prdata_o;
    next_slverr = pslverr_o;
    if (psel_i && !penable_i) begin
      next_prdata = pwrite_i ? 32'h0000_0000 : rd_val;
      next_slverr = ~hit;
    end
    rd_clr[0] = rd_acc && (paddr_i == `MPA_A_RES0A);
    rd_clr[1] = rd_acc && (paddr_i == `MPA_A_RES0B);
    rd_clr[2] = rd_acc && (paddr_i == `MPA_A_RES1A);
    rd_clr[3] = rd_acc && (paddr_i == `MPA_A_RES1B);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o <= next_prdata;
      pslverr_o <= next_slverr;
    end
  end

  // One pre-trigger sequencer and result pair per converter.
  for (genvar a = 0; a < 2; a++) begin : gen_adc
    logic             busy_q, slot_q, pre_q, fire1, done, fire;
    logic             next_busy, next_slot;
    logic [ADC_W-1:0] res_q [2];
    logic [ADC_W-1:0] next_res [2];
    logic [1:0]       unread_q, next_unread;
    logic             seq_one, first_one;
    always_comb begin
      done = adc_done_i[a] & busy_q;
      fire1 = ctrl[`MPA_C_B2B] & done & ~slot_q & ~pre0_hit;
      fire = pre0_hit | fire1;
      next_busy = fire | (busy_q & ~done);
      next_slot = fire ? fire1 : slot_q;
      next_res = res_q;
      if (done) begin
        next_res[slot_q] = adc_data[a];
      end
      next_unread = unread_q & ~rd_clr[2*a+1:2*a];
      if (done) begin
        next_unread[slot_q] = 1'b1;
      end
      seq_one = (pre0_hit & unread_q[0]) | (fire1 & unread_q[1]);
      first_one = done & ~slot_q;
    end
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        busy_q <= 1'b0;
        slot_q <= 1'b0;
        pre_q <= 1'b0;
        res_q <= '{'0, '0};
        unread_q <= 2'b00;
      end else begin
        busy_q <= next_busy;
        slot_q <= next_slot;
        pre_q <= fire;
        res_q <= next_res;
        unread_q <= next_unread;
      end
    end
    assign adc_pretrig_o[a] = pre_q;
    assign adc_slot_o[a] = slot_q;
    assign res_all[2*a] = res_q[0];
    assign res_all[2*a+1] = res_q[1];
    assign unread_all[2*a+1:2*a] = unread_q;
    assign seq_ev[a] = seq_one;
    assign first_done[a] = first_one;
  end

  // Complementary pairs with dead time, fault and mask gating.
  for (genvar p = 0; p < 3; p++) begin : gen_pair
    logic       ref_q, hi_q, lo_q, next_ref, next_hi, next_lo;
    logic [7:0] dt_q, next_dt;
    always_comb begin
      next_ref = $signed(cnt) < $signed(duty[p]);
      next_dt = dt_q;
      if (next_ref != ref_q) begin
        next_dt = 8'h00;
      end else if (tick && dt_q != 8'hff) begin
        next_dt = dt_q + 8'h01;
      end
      next_hi = (ref_q & (dt_q >= dead) & ~flt & ~omask[2*p])
                ^ ctrl[`MPA_C_HPOL];
      next_lo = (~ref_q & (dt_q >= dead) & ~flt & ~omask[2*p+1])
                ^ ctrl[`MPA_C_LPOL];
    end
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        ref_q <= 1'b0;
        dt_q <= 8'h00;
        hi_q <= 1'b0;
        lo_q <= 1'b0;
      end else begin
        ref_q <= next_ref;
        dt_q <= next_dt;
        hi_q <= next_hi;
        lo_q <= next_lo;
      end
    end
    assign pwm_o[2*p] = hi_q;
    assign pwm_o[2*p+1] = lo_q;
  end

  // Spare channels, comparator filter and the slow tick.
  logic [1:0]        idle_q;
  logic [FILT_N-2:0] hist, next_hist;
  logic              next_filt, next_slow_irq;
  logic [3:0]        pre16, next_pre16;
  logic [15:0]       slow_cnt, next_slow_cnt;

  always_comb begin
    next_hist = {hist[FILT_N-3:0], cmp_raw_i};
    next_filt = cmp_filt;
    if (&{hist, cmp_raw_i}) begin
      next_filt = 1'b1;
    end else if (~|{hist, cmp_raw_i}) begin
      next_filt = 1'b0;
    end
    next_pre16 = tick ? pre16 + 4'h1 : pre16;
    next_slow_cnt = slow_cnt;
    next_slow_irq = 1'b0;
    if (tick && pre16 == `MPA_SLOW_DIV) begin
      next_slow_irq = (slow_cnt >= speed);
      next_slow_cnt = next_slow_irq ? 16'h0000 : slow_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      idle_q <= 2'b00;
      hist <= '0;
      cmp_filt <= 1'b0;
      pre16 <= 4'h0;
      slow_cnt <= 16'h0000;
      slow_irq_o <= 1'b0;
      fast_loop_irq_o <= 1'b0;
    end else begin
      idle_q <= {ctrl[`MPA_C_LPOL], ctrl[`MPA_C_HPOL]};
      hist <= next_hist;
      cmp_filt <= next_filt;
      pre16 <= next_pre16;
      slow_cnt <= next_slow_cnt;
      slow_irq_o <= next_slow_irq;
      fast_loop_irq_o <= first_done[0];
    end
  end
  assign pwm_o[7:6] = idle_q;

  mpa_spi_master u_spi (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (wr && paddr_i == `MPA_A_SPI && !spi_busy),
    .tx_i       (pwdata_i[7:0]),
    .busy_o     (spi_busy),
    .rx_o       (spi_rx),
    .sclk_o     (spi_sclk_o),
    .mosi_o     (spi_mosi_o),
    .miso_i     (spi_miso_i),
    .cs_o       (spi_cs_o)
  );

  AST_MASKED: assert property (
    pwm_o[7:6] == {$past(ctrl[`MPA_C_LPOL]), $past(ctrl[`MPA_C_HPOL])})
    else $error("spare channel not inactive");
  AST_NO_OVERLAP: assert property (
    !((pwm_o[0] ^ $past(ctrl[`MPA_C_HPOL])) &&
      (pwm_o[1] ^ $past(ctrl[`MPA_C_LPOL]))))
    else $error("both sides of a pair active");
  AST_FAULT_OFF: assert property (fault_in |-> ##2
    (pwm_o[5:0] ^ {3{$past(ctrl[`MPA_C_LPOL]),
                     $past(ctrl[`MPA_C_HPOL])}}) == 6'h00)
    else $error("output active during fault");
  AST_AUTO_CLEAR: assert property (
    flt && !fault_in && reload && ctrl[`MPA_C_ACLR] |=> !flt)
    else $error("fault not cleared at reload");
  AST_RELOAD: assert property (
    reload && ctrl[`MPA_C_GATE] |=> reload_trig_o)
    else $error("missing reload trigger");
  AST_RESTART: assert property (
    reload_trig_o |=> dly_cnt == 16'h0000 && dly_run)
    else $error("delay counter not restarted");
  AST_PRE0: assert property (
    pre0_hit |=> adc_pretrig_o == 2'b11 && adc_slot_o == 2'b00)
    else $error("first pre-trigger missing");
  AST_B2B: assert property (
    gen_adc[0].fire1 |=> adc_pretrig_o[0] && adc_slot_o[0])
    else $error("back-to-back pre-trigger missing");
  AST_SEQERR: assert property (
    pre0_hit && unread_all[0] |=> seq_flag && delay_irq_o)
    else $error("sequence error not flagged");
  AST_DELAY: assert property (idly_hit |=> dflag && delay_irq_o)
    else $error("delay flag not raised");
  AST_FAST: assert property (
    adc_done_i[0] && gen_adc[0].busy_q && !gen_adc[0].slot_q
    |=> fast_loop_irq_o)
    else $error("fast-loop request missing");
  AST_FILTER: assert property ($changed(cmp_filt) |->
    $past(cmp_raw_i, 1) == cmp_filt && $past(cmp_raw_i, 2) == cmp_filt &&
    $past(cmp_raw_i, 3) == cmp_filt && $past(cmp_raw_i, 4) == cmp_filt)
    else $error("filter changed too early");
  AST_SLOW: assert property (slow_irq_o |-> slow_cnt == 16'h0000)
    else $error("slow tick without reload");

  COV_TRIG: cover property (reload_trig_o ##[1:300] adc_pretrig_o[0]);
  COV_FAULT: cover property (flt ##1 !flt);
  COV_B2B: cover property (gen_adc[0].fire1);
  COV_SEQ: cover property (seq_flag);
endmodule : mpa_motor_pwm

// ==== hw/mpa_cfg.svh ====
/*
  Constants of the motor PWM and ADC synchronisation block: register
  offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz core clock and a 60 MHz average timer rate.
*/
`ifndef MPA_CFG_SVH
`define MPA_CFG_SVH

`define MPA_CLK_HZ     100000000
`define MPA_TMR_HZ     60000000
// The timer tick fires 6 times in every 10 core cycles.
`define MPA_TICK_STEP  4'h6
`define MPA_TICK_WRAP  4'ha
`define MPA_DEAD_NS    500
`define MPA_DEAD_CNT   ((64'd60000000 * 64'd500) / 64'd1000000000)
`define MPA_SPI_HZ     3120000
`define MPA_SPI_HALF   (`MPA_CLK_HZ / (2 * `MPA_SPI_HZ))
`define MPA_SLOW_DIV   4'hf
`define MPA_ADC_W      12
`define MPA_FILT_N     4

`define MPA_A_CTRL     8'h00
`define MPA_A_STATUS   8'h04
`define MPA_A_COUNTER_INITIAL_VALUE    8'h08
`define MPA_A_MOD      8'h0c
`define MPA_A_DUTY0    8'h10
`define MPA_A_DUTY1    8'h14
`define MPA_A_DUTY2    8'h18
`define MPA_A_DEAD     8'h1c
`define MPA_A_PRETRIG  8'h20
`define MPA_A_IDLY     8'h24
`define MPA_A_MASK     8'h28
`define MPA_A_SPEED    8'h2c
`define MPA_A_CMPREF   8'h30
`define MPA_A_SPI      8'h34
`define MPA_A_RES0A    8'h38
`define MPA_A_RES0B    8'h3c
`define MPA_A_RES1A    8'h40
`define MPA_A_RES1B    8'h44

`define MPA_C_GATE     0
`define MPA_C_ACLR     1
`define MPA_C_HPOL     2
`define MPA_C_LPOL     3
`define MPA_C_FPOL     4
`define MPA_C_B2B      5
`define MPA_S_DLY      0
`define MPA_S_ERR      1
`define MPA_S_FLT      2

`define MPA_R_CTRL     6'h23
`define MPA_R_COUNTER_INITIAL_VALUE    16'hf448
`define MPA_R_MOD      16'h0bb7
`define MPA_R_IDLY     16'h2328
`define MPA_R_MASK     8'hc0
`define MPA_R_SPEED    16'h0ea5
`define MPA_R_CMPREF   6'h3e

`endif

// ==== hw/mpa_pkg.sv ====
/*
  Types of the motor PWM and ADC synchronisation block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mpa_pkg;
  typedef enum logic [1:0] {
    MPA_SPI_IDLE  = 2'b00,
    MPA_SPI_SHIFT = 2'b01
  } mpa_spi_state_e;
endpackage : mpa_pkg

// ==== hw/mpa_spi_master.sv ====
/*
  Gate-driver serial port: 8-bit SPI master, mode 0, chip select high.
  Assumes start_i is a one-cycle pulse given only while busy_o is low.
*/
`timescale 1ns/100ps
`include "mpa_cfg.svh"
module mpa_spi_master #(
  parameter int HALF = `MPA_SPI_HALF
) (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] tx_i,
  output logic            busy_o,
  output logic [7:0]      rx_o,
  output logic            sclk_o,
  output logic            mosi_o,
  input  wire logic       miso_i,
  output logic            cs_o
);
  mpa_pkg::mpa_spi_state_e st, next_st;
  logic [7:0] div, next_div, sh, next_sh, next_rx;
  logic [3:0] edges, next_edges;
  logic       next_sclk, next_cs;

  always_comb begin
    next_st = st;
    next_div = div;
    next_sh = sh;
    next_rx = rx_o;
    next_edges = edges;
    next_sclk = sclk_o;
    next_cs = cs_o;
    case (st)
      mpa_pkg::MPA_SPI_IDLE: begin
        if (start_i) begin
          next_st = mpa_pkg::MPA_SPI_SHIFT;
          next_sh = tx_i;
          next_cs = 1'b1;
          next_div = 8'h00;
          next_edges = 4'h0;
        end
      end
      mpa_pkg::MPA_SPI_SHIFT: begin
        if (div == 8'(HALF - 1)) begin
          next_div = 8'h00;
          next_sclk = ~sclk_o;
          next_edges = edges + 4'h1;
          if (!sclk_o) begin
            next_rx = {rx_o[6:0], miso_i};
          end else if (edges == 4'hf) begin
            next_st = mpa_pkg::MPA_SPI_IDLE;
            next_cs = 1'b0;
          end else begin
            next_sh = {sh[6:0], 1'b0};
          end
        end else begin
          next_div = div + 8'h01;
        end
      end
      default: next_st = mpa_pkg::MPA_SPI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st <= mpa_pkg::MPA_SPI_IDLE;
      div <= 8'h00;
      sh <= 8'h00;
      rx_o <= 8'h00;
      edges <= 4'h0;
      sclk_o <= 1'b0;
      cs_o <= 1'b0;
    end else begin
      st <= next_st;
      div <= next_div;
      sh <= next_sh;
      rx_o <= next_rx;
      edges <= next_edges;
      sclk_o <= next_sclk;
      cs_o <= next_cs;
    end
  end

  assign busy_o = (st != mpa_pkg::MPA_SPI_IDLE);
  assign mosi_o = sh[7];

  AST_CS_FRAME: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) busy_o |-> ##1 (cs_o || !busy_o))
    else $error("chip select low during a transfer");
endmodule : mpa_spi_master

// ==== test/mpa_adc_model.sv ====
/*
  Behavioural pair of phase-current converters facing the PWM block.
  Assumes one-cycle start pulses; slow_i picks a long conversion time.
*/
`timescale 1ns/100ps
module mpa_adc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  start_i,
  input  wire logic        slow_i,
  input  wire logic [11:0] seed_i,
  output logic      [1:0]  done_o,
  output logic      [11:0] res0_o,
  output logic      [11:0] res1_o
);
  logic [4:0] cnt [2];
  // Each converter gives a 12-bit result once a start pulse arrives.
  always_ff @(posedge clk_i) begin
    for (int a = 0; a < 2; a++) begin
      done_o[a] <= 1'b0;
      if (rst_i) begin
        cnt[a] <= 5'h00;
      end else if (start_i[a]) begin
        cnt[a] <= slow_i ? 5'h14 : 5'h03;
      end else if (cnt[a] != 5'h00) begin
        cnt[a]    <= cnt[a] - 5'h01;
        done_o[a] <= (cnt[a] == 5'h01);
      end
    end
    // Result lines carry a value only in the done cycle.
    res0_o <= rst_i ? 12'h000 : (cnt[0] == 5'h01) ? seed_i : ~res0_o;
    res1_o <= rst_i ? 12'h000 : (cnt[1] == 5'h01) ? ~seed_i : ~res1_o;
  end
endmodule : mpa_adc_model

// ==== test/mpa_motor_pwm_tb_top.sv ====
/*
  Self-checking bench of the motor PWM block over APB.
  Assumes mpa_motor_pwm and mpa_adc_model are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mpa_motor_pwm_tb_top;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, fault = 1'b0;
  logic        cmp = 1'b0, aslow = 1'b0, bad = 1'b0, s0, s1, fseen;
  logic        pready, pslverr, reload, fast, dly, slow, sclk, mosi, cs;
  logic [7:0]  paddr = 8'h00, pwm, bits;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h692c851f;
  logic [1:0]  pretrig, slot, done;
  logic [11:0] seed = 12'h000, res0, res1;
  logic [5:0]  cref;
  int          errors = 0, samples_checked = 0, n;
  logic [7:0]  ra [10] = '{8'h00, 8'h08, 8'h0c, 8'h1c, 8'h20, 8'h24,
                           8'h28, 8'h2c, 8'h30, 8'h48};
  logic [31:0] rv [10] = '{32'h23, 32'hf448, 32'hbb7, 32'h1e, 32'hf,
                           32'h2328, 32'hc0, 32'hea5, 32'h3e, 32'h0};

  always #5 core_clk_i = ~core_clk_i;

  mpa_motor_pwm u_mpa_motor_pwm (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pwm_o(pwm),
    .fault_pin_i(fault), .cmp_raw_i(cmp), .cmp_ref_o(cref),
    .reload_trig_o(reload), .adc_pretrig_o(pretrig), .adc_slot_o(slot),
    .adc_done_i(done), .adc0_result_i(res0), .adc1_result_i(res1),
    .fast_loop_irq_o(fast), .delay_irq_o(dly), .slow_irq_o(slow),
    .spi_sclk_o(sclk), .spi_mosi_o(mosi), .spi_miso_i(~mosi),
    .spi_cs_o(cs));

  mpa_adc_model u_mpa_adc_model (.clk_i(core_clk_i), .rst_i(sys_rst_i),
    .start_i(pretrig), .slow_i(aslow), .seed_i(seed), .done_o(done),
    .res0_o(res0), .res1_o(res1));

  // Sticky watchers of the pin pattern and the fast-loop request.
  always @(negedge core_clk_i) begin
    if ((pwm[0] & pwm[1]) | (pwm[7:6] != 2'b00)) bad <= 1'b1;
    if (pwm[0]) s0 <= 1'b1;
    if (pwm[1]) s1 <= 1'b1;
    if (fast) fseen <= 1'b1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk_i);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic gap(input int w, output int c);
    c = 0;
    do begin
      @(negedge core_clk_i);
      c++;
    end while (!(w == 0 ? reload : w == 1 ? slow : |pretrig));
  endtask : gap

  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    wrap_up;
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], 32'h0, rd);
      `CHK({pslverr, rd}, {i == 9, rv[i]})
    end
    `CHK(cref, 6'h3e)
    $display("reset test done");
    rnd = xs(rnd);
    seed <= rnd[11:0];
    apb(1'b1, 8'h08, 32'hffe2, rd);
    apb(1'b1, 8'h0c, 32'h1d, rd);
    apb(1'b1, 8'h2c, 32'h2, rd);
    apb(1'b1, 8'h24, 32'h28, rd);
    apb(1'b1, 8'h1c, 32'h4, rd);
    rnd = xs(rnd);
    apb(1'b1, 8'h10, {16'h0, 16'(rnd[4:0]) - 16'h0010}, rd);
    gap(0, n);
    gap(0, n);
    `CHK(n, 100)
    fseen = 1'b0;
    gap(2, n);
    `CHK(n inside {[22:29]}, 1'b1)
    `CHK(slot, 2'b00)
    gap(2, n);
    `CHK(n <= 8, 1'b1)
    `CHK(slot, 2'b11)
    // Let the watcher's update of this edge settle first.
    @(posedge core_clk_i);
    `CHK(fseen, 1'b1)
    $display("timing test done");
    apb(1'b0, 8'h38, 32'h0, rd);
    `CHK(rd, {20'h0, seed})
    apb(1'b0, 8'h40, 32'h0, rd);
    `CHK(rd, {20'h0, ~seed})
    apb(1'b0, 8'h04, 32'h0, rd);
    `CHK({dly, rd[1:0]}, 3'b111)
    aslow <= 1'b1;
    gap(0, n);
    apb(1'b1, 8'h00, 32'h22, rd);
    gap(2, n);
    gap(2, n);
    // Let the delay point of this last period pass before clearing.
    repeat (60) @(posedge core_clk_i);
    for (int i = 0; i < 4; i++) apb(1'b0, 8'h38 + 8'(4 * i), 32'h0, rd);
    apb(1'b1, 8'h04, 32'h3, rd);
    apb(1'b0, 8'h04, 32'h0, rd);
    `CHK({dly, rd[1:0]}, 3'b000)
    $display("flag test done");
    fault <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    `CHK(pwm[5:0], 6'h00)
    apb(1'b0, 8'h04, 32'h0, rd);
    `CHK({rd[5], rd[2]}, 2'b11)
    fault <= 1'b0;
    apb(1'b1, 8'h00, 32'h23, rd);
    gap(0, n);
    gap(0, n);
    s0 = 1'b0;
    s1 = 1'b0;
    gap(0, n);
    `CHK({bad, s0, s1}, 3'b011)
    gap(1, n);
    gap(1, n);
    `CHK(n, 80)
    $display("pwm test done");
    apb(1'b1, 8'h34, 32'ha5, rd);
    for (int b = 0; b < 8; b++) begin
      @(posedge sclk);
      bits[7 - b] = mosi;
      `CHK(cs, 1'b1)
    end
    do apb(1'b0, 8'h34, 32'h0, rd); while (rd[8] !== 1'b0);
    `CHK({bits, rd[7:0]}, 16'ha55a)
    apb(1'b1, 8'h00, 32'h3f, rd);
    repeat (3) @(negedge core_clk_i);
    `CHK(pwm, 8'hff)
    @(posedge core_clk_i);
    cmp <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    cmp <= 1'b0;
    apb(1'b0, 8'h04, 32'h0, rd);
    `CHK(rd[4], 1'b0)
    cmp <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    apb(1'b0, 8'h04, 32'h0, rd);
    `CHK(rd[4], 1'b1)
    $display("port test done");
    wrap_up;
  end
endmodule : mpa_motor_pwm_tb_top
